/* shared/fsfc_pkg.sv */
// Constants, types and helpers shared by the fan smoothing and floor block.
// Assumes a single 50 MHz clock and 8-bit duty values (255 is full drive).
package fsfc_pkg;

  // ==========================================================
  // Register map, byte addresses on the AHB-Lite bus
  // ==========================================================
  localparam logic [7:0] FSFC_CFG_ADDR  = 8'h00;
  localparam logic [7:0] FSFC_CTRL_ADDR = 8'h04;
  localparam logic [7:0] FSFC_MIN_ADDR  = 8'h08;
  localparam logic [7:0] FSFC_STAT_ADDR = 8'h0c;

  // Reset values.
  localparam logic [7:0]  FSFC_CFG_RESET  = 8'h00;
  localparam logic [23:0] FSFC_MIN_RESET  = 24'h000000;

  // Field positions of fan_smoothing_config.
  localparam int FSFC_RATE_LSB   = 0;
  localparam int FSFC_SMOOTH_BIT = 3;
  localparam int FSFC_GROUP_BIT  = 4;
  localparam int FSFC_FLOOR_LSB  = 5;

  // Field positions of the control and status registers.
  localparam int FSFC_LOCK_BIT      = 0;
  localparam int FSFC_SLOW_BIT      = 1;
  localparam int FSFC_AUTO_BIT      = 2;
  localparam int FSFC_STAT_LOCK_BIT = 24;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam longint FSFC_CLK_KHZ       = 50000;
  localparam longint FSFC_SWEEP_FAST_MS = 37500;
  localparam longint FSFC_SWEEP_SLOW_MS = 52200;
  localparam longint FSFC_DUTY_FULL     = 255;
  // One time slot is a full sweep at step one divided by the duty span.
  localparam longint FSFC_SLOT_FAST_CYCLES = FSFC_SWEEP_FAST_MS * FSFC_CLK_KHZ / FSFC_DUTY_FULL;
  localparam longint FSFC_SLOT_SLOW_CYCLES = FSFC_SWEEP_SLOW_MS * FSFC_CLK_KHZ / FSFC_DUTY_FULL;
  // Prescale of the drive waveform counter, about 24 kHz out.
  localparam logic [2:0] FSFC_PWM_PRESCALE = 3'h7;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic [7:0] target;
    logic       below_floor;
    logic       remote1_ctrl;
  } fsfc_drive_req_t;

  typedef enum logic [1:0] {
    FSFC_BUS_IDLE  = 2'b00,
    FSFC_BUS_WRITE = 2'b01,
    FSFC_BUS_RWAIT = 2'b11,
    FSFC_BUS_RDONE = 2'b10
  } fsfc_bus_st_t;

  // Duty step per time slot for each ramp-rate code.
  function automatic logic [5:0] fsfc_ramp_step(input logic [2:0] code);
    case (code)
      3'h0:    fsfc_ramp_step = 6'h01;
      3'h1:    fsfc_ramp_step = 6'h02;
      3'h2:    fsfc_ramp_step = 6'h03;
      3'h3:    fsfc_ramp_step = 6'h04;
      3'h4:    fsfc_ramp_step = 6'h08;
      3'h5:    fsfc_ramp_step = 6'h0c;
      3'h6:    fsfc_ramp_step = 6'h18;
      default: fsfc_ramp_step = 6'h30;
    endcase
  endfunction

endpackage

/* hdl/fsfc_ramp.sv */
// Rate limiter for one fan drive duty value.
// Assumes slot_tick is a one-cycle pulse from the owning block's divider.
`timescale 1ns/1ps
module fsfc_ramp (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       slot_tick,
  input  wire logic       smooth,
  input  wire logic [5:0] step,
  input  wire logic [7:0] target,
  output logic      [7:0] duty
);
  import fsfc_pkg::*;

  typedef struct packed {
    logic [7:0] duty;
  } fsfc_ramp_st_t;

  fsfc_ramp_st_t st;
  fsfc_ramp_st_t next_st;
  logic [8:0]    up;
  logic [8:0]    down;

  // Without smoothing the duty jumps; with it, it walks one step per slot.
  always_comb begin
    next_st = st;
    up      = {1'b0, st.duty} + {3'h0, step};
    down    = {1'b0, st.duty} - {3'h0, step};
    if (!smooth) begin
      next_st.duty = target; // see R03
    end else if (slot_tick) begin
      if (st.duty < target) begin
        next_st.duty = (up[8] || up[7:0] > target) ? target : up[7:0]; // see R01
      end else if (st.duty > target) begin
        next_st.duty = (down[8] || down[7:0] < target) ? target : down[7:0]; // see R01
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign duty = st.duty;
endmodule

/* hdl/fsfc_tach.sv */
// Speed input synchroniser and measurement gating against fan drive three.
// Assumes the speed inputs are asynchronous pins; drive3 is on this clock.
`timescale 1ns/1ps
module fsfc_tach (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] speed_in,
  input  wire logic       group,
  input  wire logic       drive3,
  output logic      [2:0] speed_sync,
  output logic      [2:0] speed_gate
);
  import fsfc_pkg::*;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [2:0] gate;
  } fsfc_tach_st_t;

  fsfc_tach_st_t st;
  fsfc_tach_st_t next_st;
  logic [2:0]    tied;

  // Inputs three and four always follow drive three; input two only when grouped.
  assign tied = {2'b11, group}; // see R04 see R05

  // A tied input is only measured while drive three is on, since the fan
  // has no supply otherwise and its pulses are meaningless.
  always_comb begin
    next_st      = st;
    next_st.meta = speed_in;
    next_st.sync = st.meta;
    for (int i = 0; i < 3; i++) begin
      next_st.gate[i] = tied[i] ? drive3 : 1'b1; // see R04 see R05
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign speed_sync = st.sync;
  assign speed_gate = st.gate;
endmodule

/* hdl/fsfc_top.sv */
// Fan smoothing and floor configuration with its AHB-Lite register slave.
// Assumes an automatic control loop outside supplies per-drive targets.
//
// Behaviour
// R01 - Ramp code 000..111 gives step 1,2,3,4,8,12,24,48; sweep depends on slow-ramp.
// R02 - With slow-ramp set, codes 010..111 sweep in about 17.4 down to 1.1 s.
// R03 - Remote-1 smoothing enable rate-limits drive changes caused by remote-1 channel.
// R04 - Grouping bit set: speed inputs two, three, four follow fan drive three.
// R05 - Grouping bit clear: only inputs three and four follow drive three.
// R06 - Below start point in auto mode, drive one gives zero or its minimum.
// R07 - Below start point in auto mode, drive two gives zero or its minimum.
// R08 - Below start point in auto mode, drive three gives zero or its minimum.
// R09 - Once locked, writes to the smoothing config register leave it unchanged.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module fsfc_top #(
  parameter longint SLOT_FAST_CYCLES = fsfc_pkg::FSFC_SLOT_FAST_CYCLES,
  parameter longint SLOT_SLOW_CYCLES = fsfc_pkg::FSFC_SLOT_SLOW_CYCLES
) (
  input  wire logic                           CLK,
  input  wire logic                           RESET_N,
  input  wire logic                           HSEL,
  input  wire logic [31:0]                    HADDR,
  input  wire logic [1:0]                     HTRANS,
  input  wire logic                           HWRITE,
  input  wire logic [2:0]                     HSIZE,
  input  wire logic [31:0]                    HWDATA,
  input  wire logic                           HREADY,
  output logic                                HREADYOUT,
  output logic                                HRESP,
  output logic      [31:0]                    HRDATA,
  input  wire fsfc_pkg::fsfc_drive_req_t [2:0] DRIVE_REQ,
  input  wire logic [2:0]                     SPEED_IN,
  output logic      [2:0]                     FAN_DRIVE,
  output logic      [2:0]                     SPEED_SYNC,
  output logic      [2:0]                     SPEED_GATE
);
  import fsfc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    fsfc_bus_st_t    bus;
    logic [7:0]      addr;
    logic [31:0]     rdata;
    logic [7:0]      cfg;
    logic            lock;
    logic            slow;
    logic            auto_en;
    logic [2:0][7:0] min_duty;
    logic [31:0]     slot_cnt;
    logic            slot_tick;
    logic [2:0]      pre_cnt;
    logic [7:0]      pwm_cnt;
    logic [2:0]      drive;
  } fsfc_top_st_t;

  localparam logic [31:0] SLOT_FAST_LAST = 32'(SLOT_FAST_CYCLES - 1);
  localparam logic [31:0] SLOT_SLOW_LAST = 32'(SLOT_SLOW_CYCLES - 1);

  fsfc_top_st_t    st;
  fsfc_top_st_t    next_st;
  logic            accept;
  logic [31:0]     slot_last;
  logic [31:0]     read_mux;
  logic [5:0]      step;
  logic [2:0]      floor_sel;
  logic [2:0][7:0] target;
  logic [2:0]      smooth;
  logic [2:0][7:0] duty;

  // ==========================================================
  // Bus decode
  // ==========================================================
  // A transfer is taken only when selected, non-idle and the bus is ready.
  // HSIZE is not checked: only whole-word accesses are supported.
  assign accept = HSEL && HTRANS[1] && HREADY;

  // Read data is assembled from the live registers in the wait cycle, so a
  // read straight after a write already sees the register as that write left it.
  always_comb begin
    read_mux = 32'h00000000;
    case (st.addr)
      FSFC_CFG_ADDR: begin
        read_mux[7:0] = st.cfg;
      end
      FSFC_CTRL_ADDR: begin
        read_mux[FSFC_LOCK_BIT] = st.lock;
        read_mux[FSFC_SLOW_BIT] = st.slow;
        read_mux[FSFC_AUTO_BIT] = st.auto_en;
      end
      FSFC_MIN_ADDR: begin
        read_mux[23:0] = st.min_duty;
      end
      FSFC_STAT_ADDR: begin
        read_mux[23:0]               = duty;
        read_mux[FSFC_STAT_LOCK_BIT] = st.lock;
      end
      default: begin
        read_mux = 32'h00000000;
      end
    endcase
  end

  // ==========================================================
  // Drive targets and smoothing
  // ==========================================================
  // Ramp step and slot length follow the rate code and the slow-ramp option.
  assign step      = fsfc_ramp_step(st.cfg[FSFC_RATE_LSB +: 3]); // see R01
  assign slot_last = st.slow ? SLOT_SLOW_LAST : SLOT_FAST_LAST; // see R01 see R02
  assign floor_sel = st.cfg[FSFC_FLOOR_LSB +: 3];

  // Below the start point in auto mode the floor choice replaces the loop's own target.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (st.auto_en && DRIVE_REQ[i].below_floor) begin
        target[i] = floor_sel[i] ? st.min_duty[i] : 8'h00; // see R06 see R07 see R08
      end else begin
        target[i] = DRIVE_REQ[i].target;
      end
      smooth[i] = st.cfg[FSFC_SMOOTH_BIT] && DRIVE_REQ[i].remote1_ctrl; // see R03
    end
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st           = st;
    next_st.slot_tick = 1'b0;

    // Bus sequencing: writes finish in their data phase, reads take one
    // wait cycle to capture the data into a flip-flop.
    case (st.bus)
      FSFC_BUS_WRITE: begin
        case (st.addr)
          FSFC_CFG_ADDR: begin
            if (!st.lock) begin
              next_st.cfg = HWDATA[7:0]; // see R09
            end
          end
          FSFC_CTRL_ADDR: begin
            // The lock only clears on reset, so later writes cannot undo it.
            next_st.lock    = st.lock | HWDATA[FSFC_LOCK_BIT]; // see R09
            next_st.slow    = HWDATA[FSFC_SLOW_BIT];
            next_st.auto_en = HWDATA[FSFC_AUTO_BIT];
          end
          FSFC_MIN_ADDR: begin
            next_st.min_duty = HWDATA[23:0];
          end
          default: begin
            next_st.cfg = st.cfg;
          end
        endcase
        next_st.bus = FSFC_BUS_IDLE;
      end
      FSFC_BUS_RWAIT: begin
        next_st.rdata = read_mux;
        next_st.bus   = FSFC_BUS_RDONE;
      end
      FSFC_BUS_RDONE: begin
        next_st.bus = FSFC_BUS_IDLE;
      end
      default: begin
        next_st.bus = FSFC_BUS_IDLE;
      end
    endcase

    // A new address phase is taken whenever this slave is not stalling.
    if (accept && st.bus != FSFC_BUS_RWAIT) begin
      next_st.addr = HADDR[7:0];
      next_st.bus  = HWRITE ? FSFC_BUS_WRITE : FSFC_BUS_RWAIT;
    end

    // Time-slot divider; restarts cleanly if clearing slow-ramp shortens the slot.
    if (st.slot_cnt >= slot_last) begin
      next_st.slot_cnt  = 32'h00000000;
      next_st.slot_tick = 1'b1; // see R01 see R02
    end else begin
      next_st.slot_cnt = st.slot_cnt + 32'h00000001;
    end

    // Drive waveform: prescaled 8-bit counter compared against the duty.
    if (st.pre_cnt == FSFC_PWM_PRESCALE) begin
      next_st.pre_cnt = 3'h0;
      next_st.pwm_cnt = st.pwm_cnt + 8'h01;
    end else begin
      next_st.pre_cnt = st.pre_cnt + 3'h1;
    end
    for (int i = 0; i < 3; i++) begin
      next_st.drive[i] = (duty[i] == 8'hff) || (st.pwm_cnt < duty[i]);
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st          <= '0;
      st.bus      <= FSFC_BUS_IDLE;
      st.cfg      <= FSFC_CFG_RESET;
      st.min_duty <= FSFC_MIN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Per-drive rate limiters
  // ==========================================================
  for (genvar g = 0; g < 3; g++) begin : gen_ramp
    fsfc_ramp u_ramp (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .slot_tick (st.slot_tick),
      .smooth    (smooth[g]),
      .step      (step),
      .target    (target[g]),
      .duty      (duty[g])
    );
  end

  // ==========================================================
  // Speed input handling
  // ==========================================================
  fsfc_tach u_tach (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .speed_in   (SPEED_IN),
    .group      (st.cfg[FSFC_GROUP_BIT]), // see R04 see R05
    .drive3     (st.drive[2]),
    .speed_sync (SPEED_SYNC),
    .speed_gate (SPEED_GATE)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  // The slave never errors; it stalls only in the read wait cycle.
  assign HREADYOUT = (st.bus != FSFC_BUS_RWAIT);
  assign HRESP     = 1'b0;
  assign HRDATA    = st.rdata;
  assign FAN_DRIVE = st.drive;
endmodule

/* verif/fsfc_top_monitor.sv */
// Concurrent checks on the ports of the fan smoothing and floor block.
// Assumes one clock, one bus master, and HREADY fed back from HREADYOUT.
`timescale 1ns/1ps
module fsfc_top_monitor (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic [2:0]  SPEED_IN,
  input wire logic [2:0]  FAN_DRIVE,
  input wire logic [2:0]  SPEED_SYNC,
  input wire logic [2:0]  SPEED_GATE
);
  // ==========================================================
  // Helpers
  // ==========================================================
  // Edges since reset, so that history checks never look into reset.
  logic [1:0] age;
  wire        take = HSEL && HTRANS[1] && HREADY;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // A read holds the bus for exactly one wait state.
  sequence seq_wait_ready;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  // ==========================================================
  // Assertions
  // ==========================================================
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("response not OKAY");
  chk_read_wait: assert property (take && !HWRITE |=> seq_wait_ready)
    else $error("read wait state wrong");
  chk_write_fast: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  chk_wait_single: assert property (!HREADYOUT |=> HREADYOUT)
    else $error("wait longer than one cycle");
  chk_rdata_hold: assert property (HREADYOUT |=> $stable(HRDATA))
    else $error("read data moved outside a read");
  chk_sync_delay: assert property (age == 2'h3 |-> SPEED_SYNC == $past(SPEED_IN, 2))
    else $error("speed sync delay wrong");
  chk_gate_tied: assert property (age == 2'h3 |-> SPEED_GATE[2:1] == {2{$past(FAN_DRIVE[2])}})
    else $error("inputs three and four not tied to drive three");
  chk_gate_free: assert property (age == 2'h3 |-> SPEED_GATE[0] || !$past(FAN_DRIVE[2]))
    else $error("input two gate low while drive three high");
endmodule

/* verif/fsfc_top_tb.sv */
// Self-checking bench for the fan smoothing and floor block.
// Assumes the block is the only slave on its AHB-Lite bus.
`timescale 1ns/1ps
module fsfc_top_tb;
  import fsfc_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic                  clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                  hreadyout, hresp, rd_pend = 1'b0, fd_prev;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            speed_in = 3'h0, fan_drive, speed_sync, speed_gate;
  logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'haaa5;
  logic [23:0]           mins, tgts, exp_d;
  logic [7:0]            v;
  fsfc_drive_req_t [2:0] drive_req = '0;
  logic [31:0]           exp_q[$];
  int                    failures = 0, samples_checked = 0, hi;
  // Short time slots so that smoothing settles within a few dozen cycles.
  localparam int         SLOT_F = 4;
  localparam int         SLOT_S = 6;

  fsfc_top #(.SLOT_FAST_CYCLES(SLOT_F), .SLOT_SLOW_CYCLES(SLOT_S)) uut (
    .CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .DRIVE_REQ(drive_req),
    .SPEED_IN(speed_in), .FAN_DRIVE(fan_drive), .SPEED_SYNC(speed_sync), .SPEED_GATE(speed_gate));

  // 50 MHz clock; speed pins wander at random to exercise the synchroniser.
  always #10 clk = ~clk;
  always @(posedge clk) speed_in <= 3'($random(seed));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", name, e, g);
    end
  endtask

  // One single transfer; the master never assumes a latency.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Read data is judged at the edge that ends each read data phase.
  always @(posedge clk) begin
    if (rd_pend && hreadyout) cmp("hrdata", exp_q.pop_front(), hrdata);
    if (hreadyout) rd_pend = hsel && htrans[1] && !hwrite;
  end

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, the unmapped word included.
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    wr_unmapped: xfer(1'b1, 8'h10, $random(seed));
    rd(8'h10, 32'h0);
    v = 8'($random(seed));
    xfer(1'b1, FSFC_CFG_ADDR, {24'h0, v});
    rd(FSFC_CFG_ADDR, {24'h0, v});
    mins = 24'($random(seed));
    xfer(1'b1, FSFC_MIN_ADDR, {8'h0, mins});
    rd(FSFC_MIN_ADDR, {8'h0, mins});
    xfer(1'b1, FSFC_CTRL_ADDR, 32'h4);
    // Every floor choice, drives below the start point in auto mode.
    for (int f = 0; f < 8; f++) begin
      tgts = 24'($random(seed));
      for (int i = 0; i < 3; i++) drive_req[i] <= '{target: tgts[8*i+:8], below_floor: 1'b1, remote1_ctrl: 1'b0};
      xfer(1'b1, FSFC_CFG_ADDR, {24'h0, 3'(f), 5'h0});
      for (int i = 0; i < 3; i++) exp_d[8*i+:8] = f[i] ? mins[8*i+:8] : 8'h00;
      rd(FSFC_STAT_ADDR, {8'h0, exp_d});
    end
    // Above the start point the floor choice has no say.
    tgts[23:16] = 8'h80;
    for (int i = 0; i < 3; i++) drive_req[i] <= '{target: tgts[8*i+:8], below_floor: 1'b0, remote1_ctrl: 1'b0};
    rd(FSFC_STAT_ADDR, {8'h0, tgts});
    // Smoothed drive one climbs 3 per slot at code 010, fast slots then slow.
    // A window of whole slots holds exactly that many ticks, whatever the phase.
    for (int s = 0; s < 2; s++) begin
      drive_req[0] <= '{target: 8'h00, below_floor: 1'b0, remote1_ctrl: 1'b0};
      xfer(1'b1, FSFC_CTRL_ADDR, {30'h0, 1'(s), 1'b0});
      xfer(1'b1, FSFC_CFG_ADDR, 32'h0a);
      drive_req[0] <= '{target: 8'h1e, below_floor: 1'b0, remote1_ctrl: 1'b1};
      repeat (4 * (s ? SLOT_S : SLOT_F) - 2) @(posedge clk);
      rd(FSFC_STAT_ADDR, {8'h0, tgts[23:8], 8'h0c});
      repeat (8 * SLOT_S) @(posedge clk);
      rd(FSFC_STAT_ADDR, {8'h0, tgts[23:8], 8'h1e});
    end
    drive_req[0] <= '{target: tgts[7:0], below_floor: 1'b0, remote1_ctrl: 1'b0};
    // Input two gate follows drive three only when grouped; drive three's
    // high time over one waveform period must match its duty of 0x80.
    for (int g = 0; g < 2; g++) begin
      xfer(1'b1, FSFC_CFG_ADDR, {27'h0, 1'(g), 4'h0});
      @(posedge clk);
      fd_prev = fan_drive[2];
      hi = 0;
      for (int n = 0; n < 2100; n++) begin
        @(negedge clk);
        cmp("speed_gate0", {31'h0, g ? fd_prev : 1'b1}, {31'h0, speed_gate[0]});
        if (n < (int'(FSFC_PWM_PRESCALE) + 1) * 256) hi += fan_drive[2];
        fd_prev = fan_drive[2];
      end
      cmp("drive3_high", 32'((int'(FSFC_PWM_PRESCALE) + 1) * 128), 32'(hi));
    end
    // Lock, then a refused write, then an attempt to clear the lock.
    xfer(1'b1, FSFC_CTRL_ADDR, 32'h5);
    xfer(1'b1, FSFC_CFG_ADDR, 32'hff);
    rd(FSFC_CFG_ADDR, 32'h10);
    xfer(1'b1, FSFC_CTRL_ADDR, 32'h0);
    rd(FSFC_CTRL_ADDR, 32'h1);
    rd(FSFC_STAT_ADDR, {8'h1, tgts});
    @(posedge clk);
    give_verdict();
  end
endmodule

bind fsfc_top fsfc_top_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
  .SPEED_IN(SPEED_IN), .FAN_DRIVE(FAN_DRIVE), .SPEED_SYNC(SPEED_SYNC), .SPEED_GATE(SPEED_GATE));
